//--- rtl/lcc_pkg.sv
package lcc_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register indices; byte address is four times the index.
  localparam logic [7:0] IDX_RX_EQUALIZER = 8'h24;
  localparam logic [7:0] IDX_TX_SWING = 8'h25;
  localparam logic [7:0] IDX_TX_DEEMPHASIS = 8'h26;
  localparam logic [7:0] IDX_IDLE_THRESHOLD = 8'h27;
  localparam logic [7:0] IDX_IDLE_RATE = 8'h2B;

  localparam logic [7:0] RST_RX_EQUALIZER = 8'h20;
  localparam logic [7:0] RST_TX_SWING = 8'h03;
  localparam logic [7:0] RST_TX_DEEMPHASIS = 8'h03;
  localparam logic [7:0] RST_IDLE_THRESHOLD = 8'h00;
  localparam logic [7:0] RST_IDLE_RATE = 8'h00;

  // Field positions.
  localparam int EQL_EN_BIT = 5;
  localparam int EQL_STAGE_LSB = 3;
  localparam int EQL_BOOST_LSB = 0;
  localparam int DEEMPH_TYPE_BIT = 7;
  localparam int THR_DEASSERT_LSB = 2;
  localparam int THR_ASSERT_LSB = 0;
  localparam int IDLE_AUTO_BIT = 5;
  localparam int IDLE_SEL_BIT = 4;
  localparam int RATE_AUTO_BIT = 1;
  localparam int RATE_SEL_BIT = 0;

  // Field codes.
  localparam logic [5:0] EQL_BYPASS = 6'h20;
  localparam logic [6:0] SWING_600 = 7'h03;
  localparam logic [6:0] SWING_800 = 7'h07;
  localparam logic [6:0] SWING_1000 = 7'h0F;
  localparam logic [6:0] SWING_1200 = 7'h1F;
  localparam logic [6:0] SWING_1400 = 7'h3F;
  localparam logic [7:0] DEEMPH_0DB = 8'h01;
  localparam logic [7:0] DEEMPH_MID = 8'h88;
  localparam logic [7:0] DEEMPH_9DB = 8'h90;
  localparam logic [7:0] DEEMPH_12DB = 8'hA0;
  localparam logic [7:0] DEEMPH_RSVD = 8'hC0;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef logic [7:0] lcc_byte_t;

  // Threshold pair in mV for a two-bit code.
  function automatic lcc_byte_t lcc_thr_mv(input logic [1:0] code,
                                           input logic deassert);
    lcc_byte_t mv;
    mv = 8'h00;
    unique case (code)
      2'h0: mv = deassert ? 8'd110 : 8'd70;
      2'h1: mv = deassert ? 8'd150 : 8'd110;
      2'h2: mv = deassert ? 8'd170 : 8'd130;
      2'h3: mv = deassert ? 8'd190 : 8'd150;
    endcase
    return mv;
  endfunction

endpackage

//--- rtl/lcc_rx_equalizer_decode.sv
`timescale 1ns/1ps
module lcc_rx_equalizer_decode (
  // Register field.
  input wire logic [5:0] code,
  // Decoded controls.
  output logic enable,
  output logic [1:0] stage,
  output logic [2:0] boost,
  output logic bypass,
  output logic pin_match
);
  import lcc_pkg::*;

  always_comb begin
    enable = code[EQL_EN_BIT];
    stage = code[EQL_STAGE_LSB +: 2];
    boost = code[EQL_BOOST_LSB +: 3];
    bypass = (code == EQL_BYPASS);
    // Codes that a strap setting could also select.
    case (code)
      6'h20, 6'h2A, 6'h30, 6'h32, 6'h39, 6'h35, 6'h37, 6'h3B,
      6'h3D: pin_match = 1'b1;
      default: pin_match = 1'b0;
    endcase
  end

endmodule

//--- rtl/lcc_tx_drive_decode.sv
`timescale 1ns/1ps
module lcc_tx_drive_decode (
  // Register fields.
  input wire logic [6:0] swing_code,
  input wire logic [7:0] deemph_code,
  // Decoded swing.
  output logic [10:0] swing_mv,
  output logic swing_valid,
  // Decoded de-emphasis.
  output logic [7:0] atten_x10,
  output logic nonzero,
  output logic reserved
);
  import lcc_pkg::*;

  always_comb begin
    swing_valid = 1'b1;
    case (swing_code)
      SWING_600: swing_mv = 11'd600;
      SWING_800: swing_mv = 11'd800;
      SWING_1000: swing_mv = 11'd1000;
      SWING_1200: swing_mv = 11'd1200;
      SWING_1400: swing_mv = 11'd1400;
      default: begin
        swing_mv = 11'd0;
        swing_valid = 1'b0;
      end
    endcase
  end

  // The mid code has no single figure, so only its presence is flagged.
  always_comb begin
    nonzero = (deemph_code != DEEMPH_0DB);
    reserved = (deemph_code == DEEMPH_RSVD);
    case (deemph_code)
      DEEMPH_9DB: atten_x10 = 8'd90;
      DEEMPH_12DB: atten_x10 = 8'd120;
      default: atten_x10 = 8'd0;
    endcase
  end

endmodule

//--- rtl/lcc_lane_regs.sv
`timescale 1ns/1ps
module lcc_lane_regs (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address.
  input wire logic [lcc_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // AXI4-Lite write data.
  input wire logic [lcc_pkg::DATA_W-1:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read address.
  input wire logic [lcc_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // AXI4-Lite read data.
  output logic [lcc_pkg::DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Analog status pins.
  input wire logic signal_detect_in,
  input wire logic rate_detect_in,
  // Receive equalizer controls.
  output logic equalizer_en,
  output logic [1:0] gain_stage_sel,
  output logic [2:0] boost_level_sel,
  output logic equalizer_bypass,
  output logic equalizer_pin_match,
  // Transmit drive controls.
  output logic [6:0] output_swing,
  output logic [10:0] swing_mv,
  output logic swing_valid,
  output logic deemph_enhanced,
  output logic [6:0] deemph_level,
  output logic [7:0] deemph_atten_x10,
  output logic deemph_nonzero,
  output logic deemph_reserved,
  // Idle and rate controls.
  output logic [7:0] idle_deassert_mv,
  output logic [7:0] idle_assert_mv,
  output logic out_mute,
  output logic signal_detect_en,
  output logic rate_5g
);
  import lcc_pkg::*;

  logic [ADDR_W-1:0] wr_addr_reg;
  logic aw_full_reg, w_full_reg, wr_lane0_reg, wr_fire, rd_take;
  logic [7:0] wr_byte_reg, wr_idx, rd_idx;
  lcc_byte_t rx_equalizer_ctrl_reg, tx_swing_ctrl_reg;
  lcc_byte_t tx_deemphasis_ctrl_reg, idle_threshold_ctrl_reg;
  lcc_byte_t idle_rate_select_ctrl_reg;
  logic [1:0] sd_sync_reg, rate_sync_reg;
  logic dec_en, dec_bypass, dec_pin, dec_swing_ok, dec_nonzero, dec_rsvd;
  logic [1:0] dec_stage;
  logic [2:0] dec_boost;
  logic [10:0] dec_mv;
  logic [7:0] dec_atten;

  // Word index of a byte address; the low two bits are ignored.
  function automatic logic [7:0] word_idx(input logic [ADDR_W-1:0] a);
    return {2'b00, a[ADDR_W-1:2]};
  endfunction

  function automatic logic idx_mapped(input logic [7:0] idx);
    return idx == IDX_RX_EQUALIZER || idx == IDX_TX_SWING ||
           idx == IDX_TX_DEEMPHASIS || idx == IDX_IDLE_THRESHOLD ||
           idx == IDX_IDLE_RATE;
  endfunction

  assign wr_idx = word_idx(wr_addr_reg);
  assign rd_idx = word_idx(araddr);
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid;
  assign rd_take = arvalid && arready;

  // Write address channel. Address and data are held until the response
  // is taken, so one write at a time is in flight.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      awready <= 1'b0;
      wr_addr_reg <= '0;
    end else if (awvalid && awready) begin
      aw_full_reg <= 1'b1;
      awready <= 1'b0;
      wr_addr_reg <= awaddr;
    end else if (bvalid && bready) begin
      aw_full_reg <= 1'b0;
      awready <= 1'b1;
    end else if (!aw_full_reg) begin
      awready <= 1'b1;
    end
  end

  // Write data channel.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      wready <= 1'b0;
      wr_byte_reg <= 8'h00;
      wr_lane0_reg <= 1'b0;
    end else if (wvalid && wready) begin
      w_full_reg <= 1'b1;
      wready <= 1'b0;
      wr_byte_reg <= wdata[7:0];
      wr_lane0_reg <= wstrb[0];
    end else if (bvalid && bready) begin
      w_full_reg <= 1'b0;
      wready <= 1'b1;
    end else if (!w_full_reg) begin
      wready <= 1'b1;
    end
  end

  // Write response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= idx_mapped(wr_idx) ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Register storage. Every bit is kept, reserved ones too, so that a
  // read returns the last write exactly.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_equalizer_ctrl_reg <= RST_RX_EQUALIZER;
      tx_swing_ctrl_reg <= RST_TX_SWING;
      tx_deemphasis_ctrl_reg <= RST_TX_DEEMPHASIS;
      idle_threshold_ctrl_reg <= RST_IDLE_THRESHOLD;
      idle_rate_select_ctrl_reg <= RST_IDLE_RATE;
    end else if (wr_fire && wr_lane0_reg) begin
      if (wr_idx == IDX_RX_EQUALIZER)
        rx_equalizer_ctrl_reg <= wr_byte_reg;
      if (wr_idx == IDX_TX_SWING)
        tx_swing_ctrl_reg <= wr_byte_reg;
      if (wr_idx == IDX_TX_DEEMPHASIS)
        tx_deemphasis_ctrl_reg <= wr_byte_reg;
      if (wr_idx == IDX_IDLE_THRESHOLD)
        idle_threshold_ctrl_reg <= wr_byte_reg;
      if (wr_idx == IDX_IDLE_RATE)
        idle_rate_select_ctrl_reg <= wr_byte_reg;
    end
  end

  // Read channel; unmapped words read zero with an error response.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (rd_take) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= idx_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
      unique case (rd_idx)
        IDX_RX_EQUALIZER: rdata <= {24'h000000, rx_equalizer_ctrl_reg};
        IDX_TX_SWING: rdata <= {24'h000000, tx_swing_ctrl_reg};
        IDX_TX_DEEMPHASIS: rdata <= {24'h000000, tx_deemphasis_ctrl_reg};
        IDX_IDLE_THRESHOLD: rdata <= {24'h000000, idle_threshold_ctrl_reg};
        IDX_IDLE_RATE: rdata <= {24'h000000, idle_rate_select_ctrl_reg};
        default: rdata <= '0;
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Analog status pins arrive asynchronously.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sd_sync_reg <= 2'b00;
      rate_sync_reg <= 2'b00;
    end else begin
      sd_sync_reg <= {sd_sync_reg[0], signal_detect_in};
      rate_sync_reg <= {rate_sync_reg[0], rate_detect_in};
    end
  end

  lcc_rx_equalizer_decode u_rx_dec (
    .code(rx_equalizer_ctrl_reg[5:0]),
    .enable(dec_en),
    .stage(dec_stage),
    .boost(dec_boost),
    .bypass(dec_bypass),
    .pin_match(dec_pin)
  );

  lcc_tx_drive_decode u_tx_dec (
    .swing_code(tx_swing_ctrl_reg[6:0]),
    .deemph_code(tx_deemphasis_ctrl_reg),
    .swing_mv(dec_mv),
    .swing_valid(dec_swing_ok),
    .atten_x10(dec_atten),
    .nonzero(dec_nonzero),
    .reserved(dec_rsvd)
  );

  // Receive equalizer outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      equalizer_en <= 1'b1;
      gain_stage_sel <= 2'b00;
      boost_level_sel <= 3'b000;
      equalizer_bypass <= 1'b1;
      equalizer_pin_match <= 1'b1;
    end else begin
      equalizer_en <= dec_en;
      gain_stage_sel <= dec_stage;
      boost_level_sel <= dec_boost;
      equalizer_bypass <= dec_bypass;
      equalizer_pin_match <= dec_pin;
    end
  end

  // Transmit drive outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      output_swing <= SWING_600;
      swing_mv <= 11'd600;
      swing_valid <= 1'b1;
      deemph_enhanced <= 1'b0;
      deemph_level <= RST_TX_DEEMPHASIS[6:0];
      deemph_atten_x10 <= 8'd0;
      deemph_nonzero <= 1'b1;
      deemph_reserved <= 1'b0;
    end else begin
      output_swing <= tx_swing_ctrl_reg[6:0];
      swing_mv <= dec_mv;
      swing_valid <= dec_swing_ok;
      deemph_enhanced <= tx_deemphasis_ctrl_reg[DEEMPH_TYPE_BIT];
      deemph_level <= tx_deemphasis_ctrl_reg[6:0];
      deemph_atten_x10 <= dec_atten;
      deemph_nonzero <= dec_nonzero;
      // The analog side leaves this code undefined; it is only flagged.
      deemph_reserved <= dec_rsvd;
    end
  end

  // Idle threshold, muting and rate outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_deassert_mv <= 8'd110;
      idle_assert_mv <= 8'd70;
      out_mute <= 1'b0;
      signal_detect_en <= 1'b0;
      rate_5g <= 1'b0;
    end else begin
      idle_deassert_mv <= lcc_thr_mv(
        idle_threshold_ctrl_reg[THR_DEASSERT_LSB +: 2], 1'b1);
      idle_assert_mv <= lcc_thr_mv(
        idle_threshold_ctrl_reg[THR_ASSERT_LSB +: 2], 1'b0);
      if (idle_rate_select_ctrl_reg[IDLE_AUTO_BIT]) begin
        out_mute <= !sd_sync_reg[1];
        signal_detect_en <= 1'b1;
      end else begin
        out_mute <= idle_rate_select_ctrl_reg[IDLE_SEL_BIT];
        signal_detect_en <= 1'b0;
      end
      if (idle_rate_select_ctrl_reg[RATE_AUTO_BIT])
        rate_5g <= rate_sync_reg[1];
      else
        rate_5g <= idle_rate_select_ctrl_reg[RATE_SEL_BIT];
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  eql_bypass_a: assert property (
    rx_equalizer_ctrl_reg[5:0] == EQL_BYPASS |=>
      equalizer_bypass && !gain_stage_sel[0] && boost_level_sel == 3'h0)
    else $error("bypass code not decoded");
  eql_fields_a: assert property (
    ##1 1'b1 |-> gain_stage_sel == $past(rx_equalizer_ctrl_reg[4:3]) &&
      boost_level_sel == $past(rx_equalizer_ctrl_reg[2:0]) &&
      equalizer_en == $past(rx_equalizer_ctrl_reg[5]))
    else $error("equalizer fields misplaced");
  eql_pin_a: assert property (
    rx_equalizer_ctrl_reg[5:0] == 6'h39 ##1
      rx_equalizer_ctrl_reg[5:0] == 6'h39 |-> equalizer_pin_match)
    else $error("strap code not matched");
  swing_map_a: assert property (
    tx_swing_ctrl_reg[6:0] == SWING_1000 |=>
      swing_mv == 11'd1000 && swing_valid)
    else $error("swing code wrong");
  deemph_type_a: assert property (
    $changed(tx_deemphasis_ctrl_reg) |=>
      deemph_enhanced == $past(tx_deemphasis_ctrl_reg[7]))
    else $error("de-emphasis type wrong");
  deemph_db_a: assert property (
    tx_deemphasis_ctrl_reg == DEEMPH_12DB |=>
      deemph_atten_x10 == 8'd120 && deemph_nonzero)
    else $error("de-emphasis level wrong");
  thresh_map_a: assert property (
    idle_threshold_ctrl_reg[3:0] == 4'h6 |=>
      idle_deassert_mv == 8'd150 && idle_assert_mv == 8'd130)
    else $error("threshold pair wrong");
  idle_manual_a: assert property (
    !idle_rate_select_ctrl_reg[5] && idle_rate_select_ctrl_reg[4] |=>
      out_mute && !signal_detect_en)
    else $error("manual mute not applied");
  idle_auto_a: assert property (
    idle_rate_select_ctrl_reg[5] |=>
      signal_detect_en && out_mute == !$past(sd_sync_reg[1]))
    else $error("automatic idle wrong");
  rate_sel_a: assert property (
    idle_rate_select_ctrl_reg[1:0] == 2'b01 |=> rate_5g)
    else $error("manual rate not applied");
  rate_auto_a: assert property (
    idle_rate_select_ctrl_reg[1] |=> rate_5g == $past(rate_sync_reg[1]))
    else $error("automatic rate wrong");
  write_back_a: assert property (
    wr_fire && wr_lane0_reg && wr_idx == IDX_TX_DEEMPHASIS |=>
      tx_deemphasis_ctrl_reg == $past(wr_byte_reg) && bvalid)
    else $error("write not stored");
  resp_hold_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  read_turn_a: assert property (
    rd_take |=> rvalid ##0 !arready)
    else $error("read answer late");

  write_seen_c: cover property (wr_fire ##1 bvalid && bready);
  read_seen_c: cover property (rd_take ##1 rvalid && rready);
  auto_mute_c: cover property (signal_detect_en && out_mute);
  rate_fast_c: cover property (rate_5g && !equalizer_bypass);

endmodule

//--- testbench/lcc_host_model.sv
`timescale 1ns/1ps
// Management host that masters the register bus. It masks reserved bits and
// swaps the reserved de-emphasis code for the 12 dB one, cleaning every byte before sending it.
module lcc_host_model (
  // Clock.
  input wire logic aclk,
  // Write channels.
  output logic [7:0] awaddr,
  output logic [2:0] awprot,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  // Read channels.
  output logic [7:0] araddr,
  output logic [2:0] arprot,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  import lcc_pkg::*;

  initial begin
    {awaddr, awprot, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arprot, arvalid, rready} = '0;
  end

  function automatic lcc_byte_t legal(input logic [7:0] a,
                                      input lcc_byte_t d);
    lcc_byte_t m;
    case (a[7:2])
      IDX_RX_EQUALIZER[5:0]: m = 8'h3F;
      IDX_TX_SWING[5:0]: m = 8'h7F;
      IDX_IDLE_THRESHOLD[5:0]: m = 8'h0F;
      IDX_IDLE_RATE[5:0]: m = 8'h33;
      default: m = 8'hFF;
    endcase
    m = d & m;
    if (a[7:2] == IDX_TX_DEEMPHASIS[5:0] && m == DEEMPH_RSVD) begin
      m = DEEMPH_12DB;
    end
    return m;
  endfunction

  task automatic wr(input logic [7:0] a, input lcc_byte_t d,
                    output lcc_byte_t sent, output logic [1:0] resp);
    bit aw_ok;
    bit w_ok;
    sent = legal(a, d);
    aw_ok = 0;
    w_ok = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, sent};
    wstrb <= 4'hF;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (!aw_ok && awready) begin
        aw_ok = 1;
        awvalid <= 1'h0;
      end
      if (!w_ok && wready) begin
        w_ok = 1;
        wvalid <= 1'h0;
      end
    end while (!bvalid);
    resp = bresp;
    bready <= 1'h0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] resp);
    bit ar_ok;
    ar_ok = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (!ar_ok && arready) begin
        ar_ok = 1;
        arvalid <= 1'h0;
      end
    end while (!rvalid);
    d = rdata;
    resp = rresp;
    rready <= 1'h0;
  endtask
endmodule

//--- testbench/lane_conditioning_config_regs_tb_top.sv
`timescale 1ns/1ps
module lane_conditioning_config_regs_tb_top;
  import lcc_pkg::*;
  logic aclk = 0, aresetn = 0, sd_in = 0, rd_in = 0;
  logic [7:0] awaddr, araddr, deemph_atten_x10;
  logic [7:0] idle_deassert_mv, idle_assert_mv;
  logic [2:0] awprot, arprot, boost_level_sel;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, gain_stage_sel;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic equalizer_en, equalizer_bypass, equalizer_pin_match;
  logic [6:0] output_swing, deemph_level;
  logic [10:0] swing_mv;
  logic swing_valid, deemph_enhanced, deemph_nonzero, deemph_reserved;
  logic out_mute, signal_detect_en, rate_5g;
  int fails = 0, n_compared = 0, cyc = 0;
  lcc_byte_t idx[5] = '{IDX_RX_EQUALIZER, IDX_TX_SWING, IDX_TX_DEEMPHASIS,
                        IDX_IDLE_THRESHOLD, IDX_IDLE_RATE};
  lcc_byte_t sh[5] = '{RST_RX_EQUALIZER, RST_TX_SWING, RST_TX_DEEMPHASIS,
                       RST_IDLE_THRESHOLD, RST_IDLE_RATE};
  lcc_byte_t q[$];

  always #25 aclk = ~aclk;

  lcc_host_model i_host (.aclk, .awaddr, .awprot, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
    .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);

  lcc_lane_regs i_dut (.aclk, .aresetn, .awaddr, .awprot, .awvalid,
    .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
    .araddr, .arprot, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .signal_detect_in(sd_in), .rate_detect_in(rd_in), .equalizer_en,
    .gain_stage_sel, .boost_level_sel, .equalizer_bypass,
    .equalizer_pin_match, .output_swing, .swing_mv, .swing_valid,
    .deemph_enhanced, .deemph_level, .deemph_atten_x10, .deemph_nonzero,
    .deemph_reserved, .idle_deassert_mv, .idle_assert_mv, .out_mute,
    .signal_detect_en, .rate_5g);

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // A hung handshake would otherwise stall the run forever.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  function automatic logic [10:0] mv(input logic [6:0] c);
    case (c)
      7'h03: return 11'h258;
      7'h07: return 11'h320;
      7'h0F: return 11'h3E8;
      7'h1F: return 11'h4B0;
      7'h3F: return 11'h578;
      default: return 11'h000;
    endcase
  endfunction

  function automatic lcc_byte_t thr(input logic [1:0] c, input bit de);
    case (c)
      2'h0: return de ? 8'h6E : 8'h46;
      2'h1: return de ? 8'h96 : 8'h6E;
      2'h2: return de ? 8'hAA : 8'h82;
      default: return de ? 8'hBE : 8'h96;
    endcase
  endfunction

  task automatic chk_all();
    lcc_byte_t e, d, ir;
    e = sh[0];
    d = sh[2];
    ir = sh[4];
    chk("eq_en", e[5], equalizer_en);
    chk("eq_stage", e[4:3], gain_stage_sel);
    chk("eq_boost", e[2:0], boost_level_sel);
    chk("eq_bypass", e[5:0] == EQL_BYPASS, equalizer_bypass);
    chk("eq_pin", e inside {8'h20, 8'h2A, 8'h30, 8'h32, 8'h39, 8'h35,
        8'h37, 8'h3B, 8'h3D}, equalizer_pin_match);
    chk("swing", sh[1][6:0], output_swing);
    chk("swing_mv", mv(sh[1][6:0]), swing_mv);
    chk("swing_ok", mv(sh[1][6:0]) != 0, swing_valid);
    chk("de_type", d[7], deemph_enhanced);
    chk("de_lvl", d[6:0], deemph_level);
    chk("de_att", d == 8'h90 ? 8'h5A : d == 8'hA0 ? 8'h78 : 8'h00,
        deemph_atten_x10);
    chk("de_nz", d != DEEMPH_0DB, deemph_nonzero);
    chk("de_rsv", d == DEEMPH_RSVD, deemph_reserved);
    chk("thr_de", thr(sh[3][3:2], 1), idle_deassert_mv);
    chk("thr_as", thr(sh[3][1:0], 0), idle_assert_mv);
    chk("sd_en", ir[5], signal_detect_en);
    chk("mute", ir[5] ? !sd_in : ir[4], out_mute);
    chk("rate", ir[1] ? rd_in : ir[0], rate_5g);
  endtask

  task automatic get(input int i);
    logic [31:0] v;
    logic [1:0] r;
    i_host.rd({idx[i][5:0], 2'h0}, v, r);
    chk("rdata", {24'h0, sh[i]}, v);
    chk("rresp", RESP_OKAY, r);
  endtask

  task automatic put(input int i, input lcc_byte_t d);
    lcc_byte_t s;
    logic [1:0] r;
    i_host.wr({idx[i][5:0], 2'h0}, d, s, r);
    chk("bresp", RESP_OKAY, r);
    sh[i] = s;
    repeat (2) @(posedge aclk);
    get(i);
    chk_all();
  endtask

  task automatic run(input int i);
    foreach (q[k]) put(i, q[k]);
    repeat (3) put(i, $urandom);
    $display("test of register %0d done", i);
  endtask

  initial begin
    logic [31:0] v;
    logic [1:0] r;
    lcc_byte_t s;
    void'($urandom(32'hc762efba));
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 5; i++) get(i);
    chk_all();
    $display("test reset done");
    q = '{8'h20, 8'h2A, 8'h30, 8'h32, 8'h39, 8'h35, 8'h37, 8'h3B, 8'h3D};
    run(0);
    q = '{8'h03, 8'h07, 8'h0F, 8'h1F, 8'h3F, 8'h7F};
    run(1);
    q = '{8'h01, 8'h88, 8'h90, 8'hA0, 8'h10, 8'hC0};
    run(2);
    q = '{};
    for (int k = 0; k < 16; k++) q.push_back(k);
    run(3);
    for (int k = 0; k < 16; k++) begin
      @(posedge aclk);
      sd_in <= $urandom;
      rd_in <= $urandom;
      repeat (4) @(posedge aclk);
      put(4, {2'h0, k[3:2], 2'h0, k[1:0]});
      sd_in <= ~sd_in;
      rd_in <= ~rd_in;
      repeat (4) @(posedge aclk);
      chk_all();
    end
    $display("test idle and rate done");
    i_host.wr(8'hA0, 8'h5A, s, r);
    chk("bresp_unmapped", RESP_SLVERR, r);
    i_host.rd(8'hA0, v, r);
    chk("rdata_unmapped", 32'h0, v);
    chk("rresp_unmapped", RESP_SLVERR, r);
    chk_all();
    for (int k = 0; k < 20; k++) put($urandom_range(4, 0), $urandom);
    $display("test unmapped and random done");
    results();
  end
endmodule
